// File: verilog/intc_status_mask.sv
// interrupt status, mask and request pin logic with an APB register port
//
// Operation
// - pin events 1 to 5 are sticky bits 0 to 4 of gpio_event_status, each reset to 0.
// - each pin event is set on the condition picked by that pin's own trigger select.
// - writing one clears a pending event bit, bits written with zero are left alone.
// - bit 1 of request_pin_config picks push-pull (0) or open drain with pull-up (1), reset 1.
// - bit 0 of request_pin_config set holds the request pin deasserted, reset 0.
// - a mask bit at 0 lets its source through and at 1 blocks it.
// - every group and first-level mask bit resets to 1.
// - group masks sit at bits 15,14,13,12,11,8,7,5,4,1,0 of group_event_mask.
// - pin events 6 to 12 are bits 5 to 11 with their own trigger select and clear by one.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "intc_defines.svh"

module intc_status_mask
#(
   parameter int PIN_COUNT = 12
)
(
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [`APB_ADDR_WIDTH-1:0]   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic [PIN_COUNT-1:0]         pin_in,
   input  wire logic [`REG_WIDTH-1:0]        first_level_pending,
   input  wire logic [`REG_WIDTH-1:0]        group_pending,
   output intc_pkg::pin_drive_t              request_pin,
   output logic                              block_irq
);

   import intc_pkg::*;

   logic [PIN_COUNT-1:0]   gpio_event_status;
   logic [1:0]             request_pin_config;
   logic [`REG_WIDTH-1:0]  group_event_mask;
   logic [`REG_WIDTH-1:0]  first_level_event_mask;
   logic [2*PIN_COUNT-1:0] pin_trigger;
   logic [`REG_WIDTH-1:0]  block_event_status;
   logic [`REG_WIDTH-1:0]  block_event_mask;
   logic                   request_active;

   logic [PIN_COUNT-1:0]   pin_event;
   logic [PIN_COUNT-1:0]   next_gpio_event_status;
   logic [`REG_WIDTH-1:0]  next_block_event_status;
   logic [`REG_WIDTH-1:0]  block_event_set;
   logic [`REG_WIDTH-1:0]  gpio_clear;
   logic [`REG_WIDTH-1:0]  index;
   logic [`REG_WIDTH-1:0]  first_level_hit;
   logic [`REG_WIDTH-1:0]  group_active;
   logic [`REG_WIDTH-1:0]  group_hit;
   logic [31:0]            read_value;
   logic                   access;
   logic                   done;
   logic                   write_done;
   logic                   read_done;
   logic                   sel_gpio;
   logic                   sel_config;
   logic                   sel_group;
   logic                   sel_first;
   logic                   sel_trigger;
   logic                   sel_block_status;
   logic                   sel_block_mask;
   logic                   mapped;
   logic                   request_assert;
   logic                   open_drain;
   logic                   output_gate;
   logic                   adc_hit;
   logic                   wr_config;
   logic                   wr_group;
   logic                   wr_first;
   logic                   wr_trigger;
   logic                   wr_block_mask;

   // registers sit on word boundaries; the index is the byte address over four
   function automatic logic index_is(input logic [`REG_WIDTH-1:0] idx,
                                     input logic [`REG_WIDTH-1:0] want);
      return idx == want;
   endfunction

   function automatic logic [31:0] widen(input logic [`REG_WIDTH-1:0] value);
      return {16'h0000, value};
   endfunction

   // bus phases: one wait state, so read data comes from a flop
   assign access     = psel & penable;
   assign done       = access & pready;
   assign write_done = done & pwrite;
   assign read_done  = done & ~pwrite;

   assign index = paddr[`APB_ADDR_WIDTH-1:2];

   assign sel_gpio         = index_is(index, `GPIO_EVENT_STATUS_IDX);
   assign sel_config       = index_is(index, `REQUEST_PIN_CONFIG_IDX);
   assign sel_group        = index_is(index, `GROUP_EVENT_MASK_IDX);
   assign sel_first        = index_is(index, `FIRST_LEVEL_EVENT_MASK_IDX);
   assign sel_trigger      = index_is(index, `PIN_TRIGGER_IDX);
   assign sel_block_status = index_is(index, `BLOCK_EVENT_STATUS_IDX);
   assign sel_block_mask   = index_is(index, `BLOCK_EVENT_MASK_IDX);

   assign mapped = sel_gpio | sel_config | sel_group | sel_first
                 | sel_trigger | sel_block_status | sel_block_mask;

   assign pslverr = pready & ~mapped;

   always_comb
   begin
      if (sel_gpio)
      begin
         read_value = {{(32-PIN_COUNT){1'b0}}, gpio_event_status};
      end
      else if (sel_config)
      begin
         read_value = {30'h0000_0000, request_pin_config};
      end
      else if (sel_group)
      begin
         read_value = widen(group_event_mask);
      end
      else if (sel_first)
      begin
         read_value = widen(first_level_event_mask);
      end
      else if (sel_trigger)
      begin
         read_value = {{(32-2*PIN_COUNT){1'b0}}, pin_trigger};
      end
      else if (sel_block_status)
      begin
         read_value = widen(block_event_status);
      end
      else if (sel_block_mask)
      begin
         read_value = widen(block_event_mask);
      end
      else
      begin
         read_value = 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else
      begin
         pready <= access & ~pready;
         if (access & ~pready & ~pwrite)
         begin
            prdata <= read_value;
         end
      end
   end

   // per-pin event detectors
   genvar i;
   generate
      for (i = 0; i < PIN_COUNT; i++)
      begin : g_pin
         pin_trigger_detect u_detect
         (
            .pclk        (pclk),
            .presetn     (presetn),
            .pin         (pin_in[i]),
            .mode        (trigger_mode_t'(pin_trigger[2*i +: 2])),
            .event_pulse (pin_event[i])
         );
      end
   endgenerate

   // sticky pin events; a new event wins over a clear in the same cycle
   assign gpio_clear = (write_done & sel_gpio) ? pwdata[`REG_WIDTH-1:0] : 16'h0000;

   assign next_gpio_event_status =
      (gpio_event_status & ~gpio_clear[PIN_COUNT-1:0]) | pin_event;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gpio_event_status <= PIN_COUNT'(`GPIO_EVENT_STATUS_RESET);
      end
      else
      begin
         gpio_event_status <= next_gpio_event_status;
      end
   end

   // write strobes, one per writable configuration register
   assign wr_config     = write_done & sel_config;
   assign wr_group      = write_done & sel_group;
   assign wr_first      = write_done & sel_first;
   assign wr_trigger    = write_done & sel_trigger;
   assign wr_block_mask = write_done & sel_block_mask;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         request_pin_config <= 2'(`REQUEST_PIN_CONFIG_RESET);
      end
      else if (wr_config)
      begin
         request_pin_config <= 2'(pwdata[15:0] & `REQUEST_PIN_CONFIG_BITS);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         group_event_mask <= `GROUP_EVENT_MASK_RESET;
      end
      else if (wr_group)
      begin
         group_event_mask <= pwdata[15:0] & `GROUP_EVENT_MASK_BITS;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         first_level_event_mask <= `FIRST_LEVEL_MASK_RESET;
      end
      else if (wr_first)
      begin
         first_level_event_mask <= pwdata[15:0] & `FIRST_LEVEL_MASK_BITS;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_trigger <= (2*PIN_COUNT)'(`PIN_TRIGGER_RESET);
      end
      else if (wr_trigger)
      begin
         pin_trigger <= pwdata[2*PIN_COUNT-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         block_event_mask <= `BLOCK_EVENT_MASK_RESET;
      end
      else if (wr_block_mask)
      begin
         block_event_mask <= pwdata[15:0] & `BLOCK_EVENT_BITS;
      end
   end

   assign output_gate = request_pin_config[`OUTPUT_GATE_BIT];
   assign open_drain  = request_pin_config[`OPEN_DRAIN_BIT];

   // first-level sources pass where their mask bit is 0
   assign first_level_hit = first_level_pending & ~first_level_event_mask
                          & `FIRST_LEVEL_MASK_BITS;

   assign adc_hit = first_level_hit[`CONVERTER_READY_BIT]
                  | first_level_hit[`COMPARATOR4_BIT]
                  | first_level_hit[`COMPARATOR3_BIT];

   // fold each first-level source into the group it belongs to
   always_comb
   begin
      group_active = group_pending;
      group_active[`PIN_GROUP_BIT] = group_pending[`PIN_GROUP_BIT]
                                   | (|gpio_event_status);
      group_active[`POWER_PATH_GROUP_BIT] = group_pending[`POWER_PATH_GROUP_BIT]
                                          | first_level_hit[`LOW_SYSTEM_VOLTAGE_BIT];
      group_active[`ONKEY_GROUP_BIT] = group_pending[`ONKEY_GROUP_BIT]
                                     | first_level_hit[`ONKEY_CHANGE_BIT];
      group_active[`WATCHDOG_GROUP_BIT] = group_pending[`WATCHDOG_GROUP_BIT]
                                        | first_level_hit[`WATCHDOG_TIMEOUT_BIT];
      group_active[`CONVERTER_GROUP_BIT] = group_pending[`CONVERTER_GROUP_BIT] | adc_hit;
   end

   assign group_hit = group_active & ~group_event_mask & `GROUP_EVENT_MASK_BITS;

   assign request_assert = ~output_gate & (|group_hit);

   // the pin is driven from flops; open drain only pulls low, push-pull drives both ways
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         request_active              <= 1'b0;
         request_pin.request_n_out   <= 1'b0;
         request_pin.request_n_oe    <= 1'b0;
         request_pin.pullup_enable   <= 1'b1;
      end
      else
      begin
         request_active              <= request_assert;
         request_pin.pullup_enable   <= open_drain;
         if (open_drain)
         begin
            request_pin.request_n_out <= 1'b0;
            request_pin.request_n_oe  <= request_assert;
         end
         else
         begin
            request_pin.request_n_out <= ~request_assert;
            request_pin.request_n_oe  <= 1'b1;
         end
      end
   end

   // block events: request assertion and accesses to unmapped addresses
   always_comb
   begin
      block_event_set = 16'h0000;
      block_event_set[`REQUEST_RISE_EVENT_BIT] = request_assert & ~request_active;
      block_event_set[`BAD_ACCESS_EVENT_BIT]   = done & ~mapped;
   end

   // a read clears the status, but an event in the same cycle survives it
   assign next_block_event_status =
      ((read_done & sel_block_status) ? 16'h0000 : block_event_status) | block_event_set;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         block_event_status <= `BLOCK_EVENT_STATUS_RESET;
         block_irq          <= 1'b0;
      end
      else
      begin
         block_event_status <= next_block_event_status;
         block_irq          <= |(next_block_event_status & ~block_event_mask);
      end
   end

endmodule // intc_status_mask

// File: verilog/intc_defines.svh
// register indices, field positions and reset values of the interrupt status and mask block
`ifndef INTC_DEFINES_SVH
`define INTC_DEFINES_SVH

`define APB_ADDR_WIDTH             18
`define REG_WIDTH                  16

`define GPIO_EVENT_STATUS_IDX      16'h4015
`define REQUEST_PIN_CONFIG_IDX     16'h4017
`define GROUP_EVENT_MASK_IDX       16'h4018
`define FIRST_LEVEL_EVENT_MASK_IDX 16'h4019
`define PIN_TRIGGER_IDX            16'h4020
`define BLOCK_EVENT_STATUS_IDX     16'h4021
`define BLOCK_EVENT_MASK_IDX       16'h4022

`define GPIO_EVENT_STATUS_RESET    16'h0000
`define REQUEST_PIN_CONFIG_RESET   16'h0002
`define GROUP_EVENT_MASK_RESET     16'hF9B3
`define FIRST_LEVEL_MASK_RESET     16'h99C0
`define PIN_TRIGGER_RESET          32'h0000_0000
`define BLOCK_EVENT_STATUS_RESET   16'h0000
`define BLOCK_EVENT_MASK_RESET     16'h0003

`define REQUEST_PIN_CONFIG_BITS    16'h0003
`define GROUP_EVENT_MASK_BITS      16'hF9B3
`define FIRST_LEVEL_MASK_BITS      16'h99C0
`define BLOCK_EVENT_BITS           16'h0003

`define OUTPUT_GATE_BIT            0
`define OPEN_DRAIN_BIT             1

`define POWER_STATE_GROUP_BIT      15
`define TEMPERATURE_GROUP_BIT      14
`define PIN_GROUP_BIT              13
`define ONKEY_GROUP_BIT            12
`define WATCHDOG_GROUP_BIT         11
`define CONVERTER_GROUP_BIT        8
`define POWER_PATH_GROUP_BIT       7
`define CLOCK_GROUP_BIT            5
`define PROM_GROUP_BIT             4
`define HIGH_CURRENT_GROUP_BIT     1
`define UNDERVOLTAGE_GROUP_BIT     0

`define LOW_SYSTEM_VOLTAGE_BIT     15
`define ONKEY_CHANGE_BIT           12
`define WATCHDOG_TIMEOUT_BIT       11
`define CONVERTER_READY_BIT        8
`define COMPARATOR4_BIT            7
`define COMPARATOR3_BIT            6

`define REQUEST_RISE_EVENT_BIT     0
`define BAD_ACCESS_EVENT_BIT       1

`endif

// File: verilog/intc_pkg.sv
// types shared by the interrupt status and mask block
package intc_pkg;

   typedef enum logic [1:0]
   {
      TRIGGER_RISING,
      TRIGGER_FALLING,
      TRIGGER_BOTH_EDGES,
      TRIGGER_HIGH_LEVEL
   } trigger_mode_t;

   typedef struct packed
   {
      logic pullup_enable;
      logic request_n_oe;
      logic request_n_out;
   } pin_drive_t;

endpackage

// File: verilog/pin_trigger_detect.sv
// per-pin event detector steered by the pin's own trigger mode
`timescale 1ns/1ps

module pin_trigger_detect
   import intc_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    pin,
   input  wire intc_pkg::trigger_mode_t mode,
   output logic                         event_pulse
);

   logic previous;
   logic primed;
   logic rose;
   logic fell;
   logic hit;

   // no edge is reported before a first sample has been taken
   assign rose = primed & pin & ~previous;
   assign fell = primed & ~pin & previous;

   always_comb
   begin
      case (mode)
         TRIGGER_RISING:     hit = rose;
         TRIGGER_FALLING:    hit = fell;
         TRIGGER_BOTH_EDGES: hit = rose | fell;
         default:            hit = pin;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         previous    <= 1'b0;
         primed      <= 1'b0;
         event_pulse <= 1'b0;
      end
      else
      begin
         previous    <= pin;
         primed      <= 1'b1;
         event_pulse <= hit;
      end
   end

endmodule // pin_trigger_detect

// File: test/intc_status_mask_checker.sv
// assertion checker for the interrupt status and mask block
`timescale 1ns/1ps
`include "intc_defines.svh"

module intc_status_mask_checker
   import intc_pkg::*;
#(
   parameter int PIN_COUNT = 12
)
(
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pwrite,
   input wire logic [`APB_ADDR_WIDTH-1:0] paddr,
   input wire logic [31:0]                pwdata,
   input wire logic [31:0]                prdata,
   input wire logic                       pready,
   input wire logic                       pslverr,
   input wire intc_pkg::pin_drive_t       request_pin,
   input wire logic                       block_irq
);
   import intc_pkg::*;
   logic [15:0] cfg;
   logic [15:0] gm;
   wire         wr_done = psel && penable && pready && pwrite && !pslverr;
   wire  [15:0] idx = paddr[17:2];
   wire         asserted = request_pin.request_n_oe && !request_pin.request_n_out;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // shadows of the two registers that steer the request pin
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cfg <= `REQUEST_PIN_CONFIG_RESET;
         gm  <= `GROUP_EVENT_MASK_RESET;
      end
      else if (wr_done && idx == `REQUEST_PIN_CONFIG_IDX)
         cfg <= pwdata[15:0] & `REQUEST_PIN_CONFIG_BITS;
      else if (wr_done && idx == `GROUP_EVENT_MASK_IDX)
         gm <= pwdata[15:0] & `GROUP_EVENT_MASK_BITS;
   end

   AST_READY_ONE_WAIT: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("ready not in second access cycle");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready && psel && penable)
      else $error("error without ready");
   AST_UNMAPPED_READ_ZERO: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   AST_GATE_HOLDS_OFF: assert property ($past(cfg[0]) |-> !asserted)
      else $error("request asserted while gated");
   AST_OPEN_DRAIN_MODE: assert property ($past(cfg[1]) |->
      request_pin.pullup_enable && !request_pin.request_n_out)
      else $error("open drain drive wrong");
   AST_CMOS_MODE: assert property (!$past(cfg[1]) |->
      request_pin.request_n_oe && !request_pin.pullup_enable)
      else $error("push pull drive wrong");
   AST_ALL_MASKED_QUIET: assert property ($past(gm) == `GROUP_EVENT_MASK_BITS |-> !asserted)
      else $error("request asserted with all groups masked");
   AST_GROUP_MASK_READ: assert property (pready && !pwrite && idx == `GROUP_EVENT_MASK_IDX
      |-> prdata == {16'h0000, gm})
      else $error("group mask read back wrong");

   cover property (pready && pslverr);
   cover property (asserted && !request_pin.pullup_enable);
   cover property (block_irq);
endmodule // intc_status_mask_checker

bind intc_status_mask intc_status_mask_checker #(.PIN_COUNT(PIN_COUNT)) checker_i
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .request_pin(request_pin), .block_irq(block_irq)
);

// File: test/request_line_host.sv
// host side of the request line: resolves the wire level from the pin drive
`timescale 1ns/1ps

module request_line_host
   import intc_pkg::*;
(
   input  wire logic                 pclk,
   input  wire intc_pkg::pin_drive_t request_pin,
   output logic                      line_level
);
   import intc_pkg::*;
   logic last = 1'b0;
   // an undriven line with no pull-up toggles instead of keeping its value
   assign line_level = request_pin.request_n_oe ? request_pin.request_n_out :
                       request_pin.pullup_enable ? 1'b1 : ~last;
   always_ff @(posedge pclk)
      last <= line_level;
endmodule // request_line_host

// File: test/pmic_interrupt_status_mask_tb_top.sv
// self-checking bench for the interrupt status and mask block
`timescale 1ns/1ps
`include "intc_defines.svh"

module pmic_interrupt_status_mask_tb_top;
   import intc_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [17:0] paddr = 18'h00000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [11:0] pin_in = 12'h000;
   logic [15:0] first_pend = 16'h0000;
   logic [15:0] group_pend = 16'h0000;
   pin_drive_t  request_pin;
   logic        block_irq;
   logic        line_level;
   logic [31:0] seed = 32'h0000CFA5;
   logic [31:0] rd;
   logic [23:0] trig;
   logic [11:0] st;
   logic        err;
   logic [1:0]  drv [4] = '{2'b10, 2'b11, 2'b10, 2'b01};
   int          error_cnt = 0;
   int          cmp_count = 0;

   intc_status_mask #(.PIN_COUNT(12)) intc_status_mask_i
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .first_level_pending(first_pend), .group_pending(group_pend),
      .request_pin(request_pin), .block_irq(block_irq)
   );
   request_line_host request_line_host_i
   (
      .pclk(pclk), .request_pin(request_pin), .line_level(line_level)
   );

   initial
      forever #2.5 pclk = ~pclk;

   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   // pins whose trigger mode is one of the modes flagged in which
   function automatic logic [11:0] hit(input logic [23:0] t, input logic [3:0] which);
      logic [11:0] h;
      for (int i = 0; i < 12; i++)
         h[i] = which[t[2*i+:2]];
      return h;
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("mismatches %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
      begin
         check(32'h0, 32'h1);
         wrap_up();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `GPIO_EVENT_STATUS_IDX, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, `REQUEST_PIN_CONFIG_IDX, 32'h0);
      check(rd, 32'h2);
      apb(1'b0, `GROUP_EVENT_MASK_IDX, 32'h0);
      check(rd, 32'hF9B3);
      apb(1'b0, `FIRST_LEVEL_EVENT_MASK_IDX, 32'h0);
      check(rd, 32'h99C0);
      apb(1'b0, 16'h4016, 32'h0);
      check({rd[30:0], err}, 32'h1);
      check(block_irq, 32'h0);
      seed = xorshift(seed);
      group_pend <= seed[15:0];
      repeat (3) @(posedge pclk);
      check(line_level, 32'h1);
      group_pend <= 16'h0000;
      // every trigger mode on pins 0 to 3, random modes elsewhere
      seed = xorshift(seed);
      trig = {seed[23:8], 8'hE4};
      apb(1'b1, `PIN_TRIGGER_IDX, {8'h00, trig});
      pin_in <= 12'hFFF;
      repeat (4) @(posedge pclk);
      st = hit(trig, 4'hD);
      apb(1'b0, `GPIO_EVENT_STATUS_IDX, 32'h0);
      check(rd, st);
      seed = xorshift(seed);
      apb(1'b1, `GROUP_EVENT_MASK_IDX, seed);
      apb(1'b0, `GROUP_EVENT_MASK_IDX, 32'h0);
      check(rd, seed & 32'hF9B3);
      apb(1'b1, `GROUP_EVENT_MASK_IDX, 32'hDFFF);
      for (int c = 0; c < 4; c++)
      begin
         apb(1'b1, `REQUEST_PIN_CONFIG_IDX, c);
         repeat (3) @(posedge pclk);
         check({request_pin.request_n_oe, line_level}, drv[c]);
      end
      apb(1'b1, `REQUEST_PIN_CONFIG_IDX, 32'h2);
      seed = xorshift(seed);
      apb(1'b1, `GPIO_EVENT_STATUS_IDX, {20'h0, seed[11:0]});
      apb(1'b0, `GPIO_EVENT_STATUS_IDX, 32'h0);
      check(rd, (st & ~seed[11:0]) | hit(trig, 4'h8));
      apb(1'b1, `GPIO_EVENT_STATUS_IDX, 32'hFFF);
      pin_in <= 12'h000;
      repeat (4) @(posedge pclk);
      apb(1'b0, `GPIO_EVENT_STATUS_IDX, 32'h0);
      check(rd, hit(trig, 4'hE));
      apb(1'b1, `GPIO_EVENT_STATUS_IDX, 32'hFFF);
      apb(1'b0, `GPIO_EVENT_STATUS_IDX, 32'h0);
      check(rd, 32'h0);
      repeat (3) @(posedge pclk);
      check(line_level, 32'h1);
      apb(1'b1, `GROUP_EVENT_MASK_IDX, 32'hFEFF);
      first_pend <= 16'h0080;
      repeat (3) @(posedge pclk);
      check(line_level, 32'h1);
      apb(1'b1, `FIRST_LEVEL_EVENT_MASK_IDX, 32'hFF7F);
      repeat (3) @(posedge pclk);
      check(line_level, 32'h0);
      first_pend <= 16'h0000;
      apb(1'b1, `BLOCK_EVENT_MASK_IDX, 32'h0);
      apb(1'b1, 16'h4016, 32'hFFFF);
      check(err, 32'h1);
      repeat (2) @(posedge pclk);
      check(block_irq, 32'h1);
      apb(1'b0, `BLOCK_EVENT_STATUS_IDX, 32'h0);
      check(rd[1], 32'h1);
      repeat (2) @(posedge pclk);
      check(block_irq, 32'h0);
      wrap_up();
   end
endmodule // pmic_interrupt_status_mask_tb_top
